/* hdl/cmd_block_pkg.sv */
/*
  Constants and carrier types for the motion command block decoder.
  Assumes a 50 MHz core clock and a cyclic output image presented in parallel.
*/
package cmd_block_pkg;

  localparam int unsigned CLK_HZ = 50000000;

  // First command word codes
  localparam logic [15:0] CODE_ABSOLUTE = 16'h0001;
  localparam logic [15:0] CODE_RELATIVE = 16'h0002;
  localparam logic [15:0] CODE_HOLD = 16'h0004;
  localparam logic [15:0] CODE_RESUME = 16'h0008;
  localparam logic [15:0] CODE_STOP = 16'h0010;
  localparam int CODE_PROGRAM_BIT = 12;
  localparam int CODE_ENC_PRESET_BIT = 14;

  // Second command word fields
  localparam int SAVE_BIT = 5;
  localparam int BLEND_REV_BIT = 4;
  localparam int CUR_SEL_BIT = 1;
  localparam logic [15:0] RESERVED_MASK = 16'h000D;
  localparam logic [15:0] SECOND_WORD_RESET = 16'h0000;

  // Parameter ranges
  localparam logic signed [31:0] POS_MIN = 32'hFF800000;
  localparam logic signed [31:0] POS_MAX = 32'h007FFFFF;
  localparam logic [31:0] SPEED_MAX = 32'h002DC6BF;
  localparam logic [15:0] RAMP_MIN = 16'h0001;
  localparam logic [15:0] RAMP_MAX = 16'h1388;
  localparam logic [15:0] JERK_MAX = 16'h1388;
  localparam logic [15:0] CURRENT_MAX = 16'h0022;

  // Indicator blink rates
  localparam int unsigned BLINK_OK_HZ = 4;
  localparam int unsigned BLINK_FAIL_HZ = 1;
  localparam int unsigned BLINK_OK_HALF = CLK_HZ / (2 * BLINK_OK_HZ);
  localparam int unsigned BLINK_FAIL_HALF = CLK_HZ / (2 * BLINK_FAIL_HZ);

  typedef struct packed {
    logic [15:0] first_command_word;
    logic [15:0] second_command_word;
    logic signed [31:0] position;
    logic [31:0] speed;
    logic [15:0] accel;
    logic [15:0] decel;
    logic [15:0] current;
    logic [15:0] jerk;
  } cmd_block_t;

  typedef struct packed {
    logic signed [31:0] target;
    logic [31:0] speed;
    logic [15:0] accel;
    logic [15:0] decel;
    logic [15:0] jerk;
  } move_params_t;

  typedef enum logic [1:0] {
    MOVE_START,
    MOVE_HOLD,
    MOVE_RESUME,
    MOVE_STOP
  } move_op_t;

endpackage

/* hdl/blink_divider.sv */
/*
  Half-period counter that toggles a lamp output while enabled.
  Assumes half period is loaded with the rate selected by the caller.
*/
`timescale 1ns/1ps
`default_nettype none
module blink_divider #(
  parameter int unsigned HALF_OK = 6250000,
  parameter int unsigned HALF_FAIL = 25000000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic enable,
  input wire logic fail,
  // Lamp
  output logic lamp
);
  logic [31:0] count_reg, count_next;
  logic lamp_reg, lamp_next;
  logic [31:0] limit;

  always_comb begin
    limit = fail ? 32'(HALF_FAIL - 1) : 32'(HALF_OK - 1);
    count_next = count_reg + 32'h1;
    lamp_next = lamp_reg;
    if (!enable) begin
      count_next = 32'h0;
      lamp_next = 1'b0;
    end else if (count_reg >= limit) begin
      count_next = 32'h0;
      lamp_next = !lamp_reg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_reg <= 32'h0;
      lamp_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      lamp_reg <= lamp_next;
    end
  end

  assign lamp = lamp_reg;
endmodule
`default_nettype wire

/* hdl/motion_command_block_decoder.sv */
/*
  Decoder for the cyclic output command block written by the network master.
  Assumes the block arrives as a parallel image from logic on clk, and that
  the flash writer and motion engine sit outside and answer with plain levels.
*/
// Contract
// - Green blink 4 Hz success, 1 Hz fail
// - After assembled save, lock until power cycle
// - Save with encoder preset; acknowledge on success
// - Blend direction: zero clockwise, one counter-clockwise
// - Current select: stored default or block word
// - Current accepted standalone or with move
// - Current 0.1 A units, 0..34, gated
// - Fixed block layout for all commands
// - Code 0001 absolute move, 24-bit signed target
// - Code 0002 relative; ramp and jerk ranges (code issues it as MOVE_START with the position word, same as 0001)
// - Code 0004 hold, parameters unused
// - Code 0008 resume with new profile words
// - Resume keeps held target position
// - Code 0010 immediate stop, parameters unused
// - Unused words ignored whatever their value
// - Immediate stop halts without ramp
// - Hold ramps to start speed, stays resumable
`timescale 1ns/1ps
`default_nettype none
module motion_command_block_decoder
  import cmd_block_pkg::*;
#(
  parameter int unsigned HALF_OK = BLINK_OK_HALF,
  parameter int unsigned HALF_FAIL = BLINK_FAIL_HALF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Output image from the master
  input wire cmd_block_t block,
  // Device state
  input wire logic [31:0] start_speed,
  input wire logic [15:0] default_current,
  input wire logic flash_done,
  input wire logic flash_error,
  input wire logic motion_held,
  // Motion engine requests
  output logic move_valid,
  output move_op_t move_op,
  output move_params_t move_params,
  output logic move_ccw,
  output logic no_ramp,
  output logic blend_ccw,
  // Current and flash
  output logic current_valid,
  output logic [15:0] current_setting,
  output logic flash_write_move,
  output logic flash_write_offset,
  // Status
  output logic offset_ack,
  output logic command_error,
  output logic locked,
  output logic error_led_green
);
  logic [15:0] w0_prev_reg, w0_prev_next;
  logic locked_reg, locked_next;
  logic waiting_move_reg, waiting_move_next;
  logic waiting_offset_reg, waiting_offset_next;
  logic blink_en_reg, blink_en_next;
  logic blink_fail_reg, blink_fail_next;
  logic ack_reg, ack_next;
  logic err_reg, err_next;
  logic mv_valid_reg, mv_valid_next;
  move_op_t op_reg, op_next;
  move_params_t par_reg, par_next;
  logic held_target_valid_reg, held_target_valid_next;
  logic signed [31:0] held_target_reg, held_target_next;
  logic no_ramp_reg, no_ramp_next;
  logic blend_reg, blend_next;
  logic cur_valid_reg, cur_valid_next;
  logic [15:0] cur_reg, cur_next;
  logic wr_move_reg, wr_move_next;
  logic wr_off_reg, wr_off_next;
  logic [15:0] rise;
  logic [15:0] w1;
  logic prog_fall;

  function automatic logic profile_ok(input cmd_block_t b, input logic [31:0] s_min);
    profile_ok = b.speed >= s_min && b.speed <= SPEED_MAX &&
                 b.accel >= RAMP_MIN && b.accel <= RAMP_MAX &&
                 b.decel >= RAMP_MIN && b.decel <= RAMP_MAX &&
                 b.jerk <= JERK_MAX;
  endfunction

  function automatic logic current_ok(input cmd_block_t b);
    // Gated word only counts when selected
    current_ok = !b.second_command_word[CUR_SEL_BIT] || b.current <= CURRENT_MAX;
  endfunction

  assign w1 = block.second_command_word;
  assign rise = block.first_command_word & ~w0_prev_reg;
  assign prog_fall = w0_prev_reg[CODE_PROGRAM_BIT] && !block.first_command_word[CODE_PROGRAM_BIT];

  always_comb begin
    w0_prev_next = block.first_command_word;
    locked_next = locked_reg;
    waiting_move_next = waiting_move_reg;
    waiting_offset_next = waiting_offset_reg;
    blink_en_next = blink_en_reg;
    blink_fail_next = blink_fail_reg;
    ack_next = ack_reg;
    err_next = err_reg;
    mv_valid_next = 1'b0;
    op_next = op_reg;
    par_next = par_reg;
    held_target_valid_next = held_target_valid_reg;
    held_target_next = held_target_reg;
    no_ramp_next = 1'b0;
    blend_next = w1[BLEND_REV_BIT];
    cur_valid_next = 1'b0;
    cur_next = cur_reg;
    wr_move_next = 1'b0;
    wr_off_next = 1'b0;
    // Flash results; locking costs a power cycle to protect endurance
    if (waiting_move_reg && flash_done) begin
      waiting_move_next = 1'b0;
      blink_en_next = 1'b1;
      blink_fail_next = flash_error;
    end
    if (waiting_offset_reg && flash_done) begin
      waiting_offset_next = 1'b0;
      ack_next = !flash_error;
    end
    if (!locked_reg) begin
      if (prog_fall && w1[SAVE_BIT]) begin
        wr_move_next = 1'b1;
        waiting_move_next = 1'b1;
        locked_next = 1'b1;
      end else if (rise[CODE_ENC_PRESET_BIT] && w1[SAVE_BIT]) begin
        wr_off_next = 1'b1;
        waiting_offset_next = 1'b1;
        // A write finishing in this very cycle still reports
        ack_next = waiting_offset_reg && flash_done && !flash_error;
      end
      // Codes are single-bit; anything else is left to other decoders
      unique case (1'b1)
        rise == CODE_STOP: begin
          op_next = MOVE_STOP;
          mv_valid_next = 1'b1;
          no_ramp_next = 1'b1;
          held_target_valid_next = 1'b0;
        end
        rise == CODE_HOLD: begin
          op_next = MOVE_HOLD;
          mv_valid_next = 1'b1;
          held_target_valid_next = 1'b1;
          held_target_next = par_reg.target;
        end
        rise == CODE_RESUME: begin
          if (!profile_ok(block, start_speed) || !current_ok(block) || !motion_held) begin
            err_next = 1'b1;
          end else begin
            op_next = MOVE_RESUME;
            mv_valid_next = 1'b1;
            par_next.speed = block.speed;
            par_next.accel = block.accel;
            par_next.decel = block.decel;
            par_next.jerk = block.jerk;
            // Position word of the block is not looked at
            par_next.target = held_target_reg;
          end
        end
        rise == CODE_ABSOLUTE || rise == CODE_RELATIVE: begin
          if (!profile_ok(block, start_speed) || !current_ok(block) ||
              block.position < POS_MIN || block.position > POS_MAX) begin
            err_next = 1'b1;
          end else begin
            op_next = MOVE_START;
            mv_valid_next = 1'b1;
            par_next = '{block.position, block.speed, block.accel, block.decel, block.jerk};
            held_target_valid_next = 1'b0;
          end
        end
        default: begin
        end
      endcase
      // Current rides with a move or stands alone
      if ((mv_valid_next && (op_next == MOVE_START || op_next == MOVE_RESUME)) ||
          (rise == 16'h0000 && w1[CUR_SEL_BIT] && !w0_prev_reg[0])) begin
        if (current_ok(block)) begin
          cur_valid_next = mv_valid_next || (w1[CUR_SEL_BIT] && cur_reg != block.current);
          cur_next = w1[CUR_SEL_BIT] ? block.current : default_current;
        end
      end
      if ((w1 & RESERVED_MASK) != 16'h0000) begin
        err_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      w0_prev_reg <= 16'h0000;
      locked_reg <= 1'b0;
      waiting_move_reg <= 1'b0;
      waiting_offset_reg <= 1'b0;
      blink_en_reg <= 1'b0;
      blink_fail_reg <= 1'b0;
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
      mv_valid_reg <= 1'b0;
      op_reg <= MOVE_STOP;
      par_reg <= '0;
      held_target_valid_reg <= 1'b0;
      held_target_reg <= 32'h00000000;
      no_ramp_reg <= 1'b0;
      blend_reg <= 1'b0;
      cur_valid_reg <= 1'b0;
      cur_reg <= 16'h0000;
      wr_move_reg <= 1'b0;
      wr_off_reg <= 1'b0;
    end else begin
      w0_prev_reg <= w0_prev_next;
      locked_reg <= locked_next;
      waiting_move_reg <= waiting_move_next;
      waiting_offset_reg <= waiting_offset_next;
      blink_en_reg <= blink_en_next;
      blink_fail_reg <= blink_fail_next;
      ack_reg <= ack_next;
      err_reg <= err_next;
      mv_valid_reg <= mv_valid_next;
      op_reg <= op_next;
      par_reg <= par_next;
      held_target_valid_reg <= held_target_valid_next;
      held_target_reg <= held_target_next;
      no_ramp_reg <= no_ramp_next;
      blend_reg <= blend_next;
      cur_valid_reg <= cur_valid_next;
      cur_reg <= cur_next;
      wr_move_reg <= wr_move_next;
      wr_off_reg <= wr_off_next;
    end
  end

  blink_divider #(
    .HALF_OK(HALF_OK),
    .HALF_FAIL(HALF_FAIL)
  ) u_blink (
    .clk(clk),
    .rst(rst),
    .enable(blink_en_reg),
    .fail(blink_fail_reg),
    .lamp(error_led_green)
  );

  assign move_valid = mv_valid_reg;
  assign move_op = op_reg;
  assign move_params = par_reg;
  assign move_ccw = 1'b0;
  assign no_ramp = no_ramp_reg;
  assign blend_ccw = blend_reg;
  assign current_valid = cur_valid_reg;
  assign current_setting = cur_reg;
  assign flash_write_move = wr_move_reg;
  assign flash_write_offset = wr_off_reg;
  assign offset_ack = ack_reg;
  assign command_error = err_reg;
  assign locked = locked_reg;
endmodule
`default_nettype wire

/* bench/motion_command_block_decoder_chk.sv */
/*
  Assertions on the command block decoder, bound to its top module.
  Assumes the image on block changes only just after rising clock edges.
*/
`timescale 1ns/1ps
`default_nettype none
module motion_command_block_decoder_chk
  import cmd_block_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Decoder inputs
  input wire cmd_block_t block,
  input wire logic [15:0] default_current,
  input wire logic flash_done,
  input wire logic flash_error,
  // Decoder outputs
  input wire logic move_valid,
  input wire move_op_t move_op,
  input wire logic no_ramp,
  input wire logic blend_ccw,
  input wire logic current_valid,
  input wire logic [15:0] current_setting,
  input wire logic flash_write_move,
  input wire logic flash_write_offset,
  input wire logic offset_ack,
  input wire logic command_error,
  input wire logic locked
);
  logic [15:0] pw_reg, pw_next, rise;
  logic ok;
  always_comb begin
    pw_next = block.first_command_word;
  end
  // Cleared by reset so a word standing at release counts as a rise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) pw_reg <= 16'h0000;
    else pw_reg <= pw_next;
  end
  assign rise = block.first_command_word & ~pw_reg;
  assign ok = !locked && (block.second_command_word & RESERVED_MASK) == 16'h0000;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_STOP: assert property (ok && rise == CODE_STOP
    |=> move_valid && move_op == MOVE_STOP && no_ramp) else $error("stop not issued");
  AST_HOLD: assert property (ok && rise == CODE_HOLD
    |=> move_valid && move_op == MOVE_HOLD && !no_ramp) else $error("hold not issued");
  AST_RAMP: assert property (no_ramp
    |-> move_valid && move_op == MOVE_STOP) else $error("no_ramp outside stop");
  AST_QUIET: assert property ($past(locked)
    |-> !move_valid && !current_valid && !flash_write_offset) else $error("acted while locked");
  AST_LOCK: assert property (locked |=> locked) else $error("lock dropped");
  AST_SAVE: assert property (!locked && pw_reg[CODE_PROGRAM_BIT]
    && !block.first_command_word[CODE_PROGRAM_BIT] && block.second_command_word[SAVE_BIT]
    |=> flash_write_move && locked) else $error("save not started");
  AST_ACK: assert property ($rose(offset_ack)
    |-> $past(flash_done && !flash_error)) else $error("ack without good write");
  AST_BLEND: assert property (!$past(rst)
    |-> blend_ccw == $past(block.second_command_word[BLEND_REV_BIT])) else $error("blend dir");
  AST_CUR: assert property (move_valid && move_op == MOVE_START
    |-> current_valid && current_setting == ($past(block.second_command_word[CUR_SEL_BIT])
    ? $past(block.current) : $past(default_current))) else $error("current select");
  AST_RANGE: assert property (ok && rise == CODE_ABSOLUTE && block.position > POS_MAX
    |=> !move_valid && command_error) else $error("range not refused");
  AST_STICKY: assert property (command_error |=> command_error) else $error("error cleared");
  COV_RESUME: cover property (move_valid && move_op == MOVE_RESUME);
  COV_OFFSET: cover property (flash_write_offset);
  COV_LOCK: cover property ($rose(locked));
endmodule
bind motion_command_block_decoder motion_command_block_decoder_chk chk_i (.clk(clk), .rst(rst),
  .block(block), .default_current(default_current), .flash_done(flash_done),
  .flash_error(flash_error), .move_valid(move_valid), .move_op(move_op), .no_ramp(no_ramp),
  .blend_ccw(blend_ccw), .current_valid(current_valid), .current_setting(current_setting),
  .flash_write_move(flash_write_move), .flash_write_offset(flash_write_offset),
  .offset_ack(offset_ack), .command_error(command_error), .locked(locked));
`default_nettype wire

/* bench/output_image_master.sv */
/*
  Network master and flash writer seen from the decoder.
  Assumes the bench hands over the next image; flash answers three cycles after a write.
*/
`timescale 1ns/1ps
`default_nettype none
module output_image_master
  import cmd_block_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // From the bench
  input wire cmd_block_t img,
  input wire logic fail,
  input wire logic wr,
  // Toward the decoder
  output cmd_block_t block,
  output logic flash_done,
  output logic flash_error
);
  logic [1:0] cnt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      block <= '0;
      cnt <= 2'h0;
      flash_done <= 1'b0;
      flash_error <= 1'b0;
    end else begin
      block <= img;
      flash_done <= cnt == 2'h1;
      // Outcome only valid with done; toggles otherwise so nothing leans on it
      flash_error <= (cnt == 2'h1) ? fail : ~flash_error;
      cnt <= wr ? 2'h3 : (cnt != 2'h0) ? cnt - 2'h1 : 2'h0;
    end
  end
endmodule
`default_nettype wire

/* bench/tb_motion_command_block_decoder.sv */
/*
  Self-checking bench for the command block decoder with a master model.
  Assumes short blink half periods of 4 and 16 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb_motion_command_block_decoder
  import cmd_block_pkg::*;
();
  logic clk = 1'b0, rst = 1'b1, fail = 1'b0, held = 1'b0;
  logic fd, fe, mv, no_ramp, blend, cv, fwm, fwo, ack, err, locked, led;
  cmd_block_t img = '0, block;
  move_op_t op;
  move_params_t mp;
  logic [15:0] cur;
  logic signed [31:0] tgt;
  int bad_count = 0, n_tests = 0, seed = 37860, k;
  output_image_master output_image_master_i (.clk(clk), .rst(rst), .img(img), .fail(fail),
    .wr(fwm | fwo), .block(block), .flash_done(fd), .flash_error(fe));
  motion_command_block_decoder #(.HALF_OK(4), .HALF_FAIL(16)) motion_command_block_decoder_i (
    .clk(clk), .rst(rst), .block(block), .start_speed(32'h00000064),
    .default_current(16'h0011), .flash_done(fd), .flash_error(fe), .motion_held(held),
    .move_valid(mv), .move_op(op), .move_params(mp), .move_ccw(), .no_ramp(no_ramp),
    .blend_ccw(blend), .current_valid(cv), .current_setting(cur), .flash_write_move(fwm),
    .flash_write_offset(fwo), .offset_ack(ack), .command_error(err), .locked(locked),
    .error_led_green(led));
  function automatic logic [15:0] exp_cur(logic [15:0] w1, logic [15:0] c);
    return w1[CUR_SEL_BIT] ? c : 16'h0011;
  endfunction
  // Word returns to zero first so every code is a fresh rise
  task automatic go(input logic [15:0] w0, w1, input logic signed [31:0] p, input logic [15:0] c);
    @(posedge clk) img.first_command_word <= 16'h0000;
    @(posedge clk) img <= '{w0, w1, p, 32'h00000064 + $unsigned($random(seed)) % 32'h002DC65C,
      16'h0001 + 16'($unsigned($random(seed)) % 32'h1388), 16'h1388, c,
      16'($unsigned($random(seed)) % 32'h1389)};
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    forever #10 clk = ~clk;
  end
  initial begin
    #200000;
    bad_count++;
    test_done();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      tgt = (i == 0) ? POS_MIN : (i == 1) ? POS_MAX : $random(seed) >>> 9;
      go(i % 2 ? CODE_RELATIVE : CODE_ABSOLUTE, 16'($random(seed)) & 16'h0012, tgt,
        16'($unsigned($random(seed)) % 32'h23));
      `CHK("move_valid", 1'b1, mv)
      `CHK("move_op", MOVE_START, op)
      `CHK("target", tgt, mp.target)
      `CHK("speed", img.speed, mp.speed)
      `CHK("ramps", {img.accel, img.decel}, {mp.accel, mp.decel})
      `CHK("current", exp_cur(img.second_command_word, img.current), cur)
      `CHK("blend", img.second_command_word[BLEND_REV_BIT], blend)
    end
    $display("test moves done");
    go(CODE_HOLD, 16'h0000, 32'sh00123456, 16'h0030);
    `CHK("hold_op", MOVE_HOLD, op)
    `CHK("hold_ramp", 1'b0, no_ramp)
    @(posedge clk) held <= 1'b1;
    go(CODE_RESUME, 16'h0000, 32'sh00000077, 16'h0005);
    `CHK("resume_op", MOVE_RESUME, op)
    `CHK("resume_target", tgt, mp.target)
    `CHK("resume_speed", img.speed, mp.speed)
    go(CODE_STOP, 16'h0000, 32'sh7FFFFFFF, 16'hFFFF);
    `CHK("stop_op", MOVE_STOP, op)
    `CHK("stop_no_ramp", 1'b1, no_ramp)
    `CHK("stop_err", 1'b0, err)
    go(16'h0000, 16'h0002, 32'sh0, 16'h0009);
    `CHK("cur_alone", 1'b1, cv)
    `CHK("cur_alone_val", 16'h0009, cur)
    $display("test hold resume stop done");
    go(16'h4000, 16'h0020, 32'sh0, 16'h0003);
    `CHK("offset_write", 1'b1, fwo)
    for (k = 0; k < 10 && !ack; k++) @(posedge clk);
    #1 `CHK("offset_ack", 1'b1, ack)
    go(CODE_ABSOLUTE, 16'h0000, POS_MAX + 32'sh1, 16'h0003);
    `CHK("range_move", 1'b0, mv)
    `CHK("range_err", 1'b1, err)
    $display("test offset and range done");
    for (int f = 0; f < 2; f++) begin
      @(posedge clk) fail <= f[0];
      if (f == 1) begin
        img.first_command_word <= 16'h0000;
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        go(CODE_STOP, 16'h0004, 32'sh0, 16'h0003);
        `CHK("reserved_err", 1'b1, err)
      end
      go(16'h1000, 16'h0020, 32'sh0, 16'h0003);
      go(16'h0000, 16'h0020, 32'sh0, 16'h0003);
      `CHK("locked", 1'b1, locked)
      for (k = 0; k < 20 && !led; k++) begin @(posedge clk); #1; end
      for (k = 0; k < 40 && led; k++) begin @(posedge clk); #1; end
      `CHK("blink_half", f ? 16 : 4, k)
      go(CODE_STOP, 16'h0000, 32'sh0, 16'h0003);
      `CHK("locked_quiet", 1'b0, mv)
      $display("test save %0d done", f);
    end
    test_done();
  end
endmodule
`default_nettype wire
